// file: shared/mrv_pkg.sv
// shared constants of the reset, mode and vector configuration block
package mrv_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PART_HI = 8'h1a;
    localparam logic [7:0] IDX_PART_LO = 8'h1b;
    localparam logic [7:0] IDX_VERSION = 8'h1c;
    localparam logic [7:0] IDX_MODE    = 8'h20;
    localparam logic [7:0] IDX_VBASE   = 8'h21;
    localparam logic [7:0] IDX_OSC     = 8'h22;
    localparam logic [7:0] IDX_WDOG    = 8'h23;
    localparam logic [7:0] IDX_STATUS  = 8'h24;
    localparam logic [7:0] IDX_MASK    = 8'h25;
    localparam logic [7:0] IDX_VECTOR  = 8'h26;
    // part identification field positions
    localparam int PID_MAJFAM_LSB = 12;
    localparam int PID_MINFAM_LSB = 6;
    localparam int PID_MAJREV_LSB = 4;
    localparam int PID_MINREV_LSB = 0;
    // mode register bits
    localparam int MODE_BIT    = 0;
    localparam int FREEZE_BIT  = 1;
    // status / mask bits
    localparam int EV_SPURIOUS = 0;
    localparam int EV_ABORT    = 1;
    localparam int EV_SECURE   = 2;
    localparam int EV_CLKMON   = 3;
    localparam int EV_WDOG     = 4;
    localparam int EV_W        = 5;
    // reset values
    localparam logic [7:0] VBASE_RST  = 8'hff;
    localparam logic       OSC_EN_RST = 1'b1;
    localparam logic [2:0] WDOG_RST   = 3'h0;
    localparam logic [7:0] VBASE_W    = 8'hff;
    // fixed reset vectors
    localparam logic [15:0] VEC_RESET  = 16'hfffe;
    localparam logic [15:0] VEC_CLKMON = 16'hfffc;
    localparam logic [15:0] VEC_WDOG   = 16'hfffa;
    // interrupt table, highest priority first
    localparam int IRQ_N = 11;
    localparam logic [7:0] IRQ_OFS [IRQ_N] = '{8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hf0,
        8'hd8, 8'hc8, 8'hc6, 8'hba, 8'hb8, 8'h8a};
    localparam logic [7:0] OFS_SPURIOUS = 8'h80;
    // bit i of these belongs to table entry i
    localparam logic [IRQ_N-1:0] IRQ_NOMASK = 11'h003;
    localparam logic [IRQ_N-1:0] IRQ_XMASK  = 11'h004;
    typedef enum logic [1:0] {ST_HOLD, ST_LOAD, ST_RUN} mrv_state_t;
endpackage

// file: logic/mrv_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module mrv_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // pin and filtered level
    input  wire logic pinIn,
    output logic      levelOut
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk) begin
        if (reset) begin
            levelOut <= RST_VAL;
        end else if (s2_q == s3_q) begin
            levelOut <= s3_q;
        end
    end
endmodule

// file: logic/mrv_prio_sel.sv
// fixed priority selector, lowest index wins
`timescale 1ns/1ns
module mrv_prio_sel #(
    parameter int N = 4
) (
    // requests
    input  wire logic [N-1:0]         req,
    // result
    output logic                      hit,
    output logic [$clog2(N)-1:0]      idx
);
    always_comb begin
        hit = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                hit = 1'b1;
                idx = ($clog2(N))'(i);
            end
        end
    end
endmodule

// file: logic/mrv_top.sv
// reset sequencing, operating mode, part id and interrupt vector logic
//
// Behaviour
// - part id readable as two read-only bytes, high then low.
// - id fields: family 15-12, subfamily 11-6, revisions 5-4 and 3-0.
// - version word from flash information row identifies memory controller.
// - mode input held during reset, latched when reset releases.
// - mode bit shows mode, 1 normal, 0 special, limited switching.
// - normal mode starts from reset vector in on-chip memory.
// - special mode enables debug logic and monitor awaiting serial commands.
// - power, low voltage, pin, illegal address reset use top vector.
// - clock monitor reset has own vector, only with oscillator enabled.
// - watchdog reset has own vector, enabled by nonzero rate field.
// - interrupt vector is software base plus fixed source offset.
// - fixed priority, higher offset wins, trap and software unmaskable.
// - each vector entry is a sixteen-bit handler address.
// - flash load holds CPU in reset until configuration done.
// - double fault during load leaves protection and security active.
// - reset during flash command aborts it immediately.
// - reset never clears or initialises RAM.
// - software option freezes modules while debug logic active.
`timescale 1ns/1ns
module mrv_top #(
    parameter logic [3:0]  MAJ_FAMILY = 4'h1,   // arbitrary id value
    parameter logic [5:0]  MIN_FAMILY = 6'h02,  // arbitrary id value
    parameter logic [1:0]  MAJ_MASK   = 2'h1,   // arbitrary id value
    parameter logic [3:0]  MIN_MASK   = 4'h1,   // arbitrary id value
    parameter logic [15:0] MON_ENTRY  = 16'hff00
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    // reset sources
    input  wire logic                     porEvt,
    input  wire logic                     lowVoltEvt,
    input  wire logic                     pinResetN,
    input  wire logic                     illegalAddrEvt,
    input  wire logic                     clkMonFail,
    input  wire logic                     wdogTimeout,
    // mode pin
    input  wire logic                     modeSelectIn,
    // flash controller
    input  wire logic                     flashCfgDone,
    input  wire logic                     flashDoubleFault,
    input  wire logic                     flashCmdBusy,
    input  wire logic [15:0]              flashVersionId,
    output logic                          flashAbort,
    output logic                          flashSecure,
    // cpu side
    output logic                          cpuHold,
    output logic [15:0]                   cpuStartVector,
    output logic                          monitorRun,
    output logic                          debugActive,
    output logic                          freezeOut,
    // interrupt requests and acknowledge
    input  wire logic [mrv_pkg::IRQ_N-1:0] irqReq,
    input  wire logic                     cpuIMask,
    input  wire logic                     cpuXMask,
    input  wire logic                     irqAck,
    output logic                          irqPending,
    output logic [15:0]                   irqVector,
    output logic                          irqVecValid,
    // status interrupt
    output logic                          irq
);
    mrv_pkg::mrv_state_t        state_q;
    logic                       pinRstN;
    logic                       modeSync;
    logic                       modeBit_q;
    logic                       freezeEn_q;
    logic [7:0]                 vbase_q;
    logic                       oscEn_q;
    logic [2:0]                 wdogRate_q;
    logic [mrv_pkg::EV_W-1:0]   status_q;
    logic [mrv_pkg::EV_W-1:0]   mask_q;
    logic [mrv_pkg::EV_W-1:0]   events;
    logic [mrv_pkg::EV_W-1:0]   readClr_q;
    logic [15:0]                resetVec_q;
    logic [15:0]                partId;
    logic                       rstTop;
    logic                       rstClk;
    logic                       rstWdog;
    logic                       sysReq;
    logic                       ctlRst;
    logic                       setup;
    logic                       wrEn;
    logic                       rdEn;
    logic [7:0]                 regIdx;
    logic                       addrOk;
    logic [31:0]                rdMux;
    logic                       hitMap;
    logic [mrv_pkg::IRQ_N-1:0]  eligible;
    logic                       selHit;
    logic [3:0]                 selIdx;

    mrv_sync3 #(.RST_VAL(1'b1)) u_pinSync (
        .clk      (clk),
        .reset    (reset),
        .pinIn    (pinResetN),
        .levelOut (pinRstN)
    );

    // mode pin keeps sampling while reset is held, so its level is settled at release
    mrv_sync3 #(.RST_VAL(1'b1)) u_modeSync (
        .clk      (clk),
        .reset    (1'b0),
        .pinIn    (modeSelectIn),
        .levelOut (modeSync)
    );

    assign partId = {MAJ_FAMILY, MIN_FAMILY, MAJ_MASK, MIN_MASK};

    // reset sources
    assign rstTop  = porEvt | lowVoltEvt | ~pinRstN | illegalAddrEvt;
    assign rstClk  = clkMonFail & oscEn_q;
    assign rstWdog = wdogTimeout & (wdogRate_q != 3'h0);
    assign sysReq  = rstTop | rstClk | rstWdog;
    // control registers except the mask re-initialise on every reset; status and mask survive internal ones
    assign ctlRst  = reset | (state_q == mrv_pkg::ST_HOLD);

    // sequencer: hold while a source is active, then flash load, then run
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= mrv_pkg::ST_HOLD;
            cpuHold <= 1'b1;
        end else if (sysReq) begin
            state_q <= mrv_pkg::ST_HOLD;
            cpuHold <= 1'b1;
        end else begin
            case (state_q)
                mrv_pkg::ST_HOLD: begin
                    state_q <= mrv_pkg::ST_LOAD;
                    cpuHold <= 1'b1;
                end
                mrv_pkg::ST_LOAD: begin
                    if (flashCfgDone) begin
                        state_q <= mrv_pkg::ST_RUN;
                        cpuHold <= 1'b0;
                    end else begin
                        cpuHold <= 1'b1;
                    end
                end
                mrv_pkg::ST_RUN: begin
                    cpuHold <= 1'b0;
                end
                default: begin
                    state_q <= mrv_pkg::ST_HOLD;
                    cpuHold <= 1'b1;
                end
            endcase
        end
    end

    // ram arrays get no clear strobe: their contents pass through any reset
    // untouched, only the registers of this block restart

    // vector chosen by the source that arrived, top group first
    always_ff @(posedge clk) begin
        if (reset) begin
            resetVec_q <= mrv_pkg::VEC_RESET;
        end else if (rstTop) begin
            resetVec_q <= mrv_pkg::VEC_RESET;
        end else if (rstClk) begin
            resetVec_q <= mrv_pkg::VEC_CLKMON;
        end else if (rstWdog) begin
            resetVec_q <= mrv_pkg::VEC_WDOG;
        end
    end

    // mode latched on the release edge; software may only leave special mode
    always_ff @(posedge clk) begin
        if (state_q == mrv_pkg::ST_HOLD && !sysReq && !reset) begin
            modeBit_q <= modeSync;
        end else if (reset) begin
            modeBit_q <= 1'b1;
        end else if (wrEn && regIdx == mrv_pkg::IDX_MODE && pwdata[mrv_pkg::MODE_BIT]) begin
            modeBit_q <= 1'b1;
        end
    end

    // cpu start-up outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            cpuStartVector <= mrv_pkg::VEC_RESET;
            monitorRun     <= 1'b0;
            debugActive    <= 1'b0;
            freezeOut      <= 1'b0;
        end else begin
            cpuStartVector <= modeBit_q ? resetVec_q : MON_ENTRY;
            monitorRun     <= ~modeBit_q;
            debugActive    <= ~modeBit_q;
            freezeOut      <= freezeEn_q & ~modeBit_q;
        end
    end

    // flash abort and post-load security
    always_ff @(posedge clk) begin
        if (reset) begin
            flashAbort  <= flashCmdBusy;
            flashSecure <= 1'b0;
        end else begin
            flashAbort <= sysReq & flashCmdBusy;
            if (state_q == mrv_pkg::ST_LOAD && flashCfgDone && !sysReq) begin
                flashSecure <= flashDoubleFault;
            end
        end
    end

    // apb decode: answer is ready in the access cycle, no wait states
    assign setup  = psel & ~penable;
    assign wrEn   = psel & penable & pready & pwrite;
    assign rdEn   = psel & penable & pready & ~pwrite;
    assign regIdx = paddr[9:2];
    assign addrOk = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);

    always_comb begin
        rdMux  = 32'h0;
        hitMap = addrOk;
        case (regIdx)
            mrv_pkg::IDX_PART_HI: rdMux[7:0] = partId[15:8];
            mrv_pkg::IDX_PART_LO: rdMux[7:0] = partId[7:0];
            mrv_pkg::IDX_VERSION: rdMux[15:0] = flashVersionId;
            mrv_pkg::IDX_MODE: begin
                rdMux[mrv_pkg::MODE_BIT]   = modeBit_q;
                rdMux[mrv_pkg::FREEZE_BIT] = freezeEn_q;
            end
            mrv_pkg::IDX_VBASE:   rdMux[7:0] = vbase_q;
            mrv_pkg::IDX_OSC:     rdMux[0] = oscEn_q;
            mrv_pkg::IDX_WDOG:    rdMux[2:0] = wdogRate_q;
            mrv_pkg::IDX_STATUS:  rdMux[mrv_pkg::EV_W-1:0] = status_q;
            mrv_pkg::IDX_MASK:    rdMux[mrv_pkg::EV_W-1:0] = mask_q;
            mrv_pkg::IDX_VECTOR:  rdMux[15:0] = irqVector;
            default:              hitMap = 1'b0;
        endcase
    end

    // read data captured in setup; the read-clear only drops bits actually seen
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata    <= 32'h0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            readClr_q <= '0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata    <= pwrite ? 32'h0 : rdMux;
                pslverr   <= ~hitMap;
                readClr_q <= (hitMap && regIdx == mrv_pkg::IDX_STATUS && !pwrite) ?
                             status_q : '0;
            end
        end
    end

    // writable control registers
    always_ff @(posedge clk) begin
        if (ctlRst) begin
            freezeEn_q <= 1'b0;
            vbase_q    <= mrv_pkg::VBASE_RST;
            oscEn_q    <= mrv_pkg::OSC_EN_RST;
            wdogRate_q <= mrv_pkg::WDOG_RST;
        end else if (wrEn) begin
            case (regIdx)
                mrv_pkg::IDX_MODE:  freezeEn_q <= pwdata[mrv_pkg::FREEZE_BIT];
                mrv_pkg::IDX_VBASE: vbase_q <= pwdata[7:0];
                mrv_pkg::IDX_OSC:   oscEn_q <= pwdata[0];
                mrv_pkg::IDX_WDOG:  wdogRate_q <= pwdata[2:0];
                default:            vbase_q <= vbase_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mask_q <= '0;
        end else if (wrEn && regIdx == mrv_pkg::IDX_MASK) begin
            mask_q <= pwdata[mrv_pkg::EV_W-1:0];
        end
    end

    // sticky status: a new event wins over a read-clear in the same cycle
    always_comb begin
        events = '0;
        events[mrv_pkg::EV_SPURIOUS] = irqAck & ~selHit;
        events[mrv_pkg::EV_ABORT]    = sysReq & flashCmdBusy;
        events[mrv_pkg::EV_SECURE]   = (state_q == mrv_pkg::ST_LOAD) & flashCfgDone &
                                       flashDoubleFault;
        events[mrv_pkg::EV_CLKMON]   = rstClk;
        events[mrv_pkg::EV_WDOG]     = rstWdog;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status_q <= '0;
            irq      <= 1'b0;
        end else begin
            status_q <= (status_q & ~(rdEn ? readClr_q : '0)) | events;
            irq      <= |(status_q & mask_q);
        end
    end

    // interrupt selection: table holds implemented sources only, so reserved
    // slots cannot be picked
    assign eligible = irqReq & (mrv_pkg::IRQ_NOMASK |
                      (mrv_pkg::IRQ_XMASK & {mrv_pkg::IRQ_N{~cpuXMask}}) |
                      (~(mrv_pkg::IRQ_NOMASK | mrv_pkg::IRQ_XMASK) &
                       {mrv_pkg::IRQ_N{~cpuIMask}}));

    mrv_prio_sel #(.N(mrv_pkg::IRQ_N)) u_sel (
        .req (eligible),
        .hit (selHit),
        .idx (selIdx)
    );

    always_ff @(posedge clk) begin
        if (ctlRst) begin
            irqPending  <= 1'b0;
            irqVector   <= {mrv_pkg::VBASE_RST, mrv_pkg::OFS_SPURIOUS};
            irqVecValid <= 1'b0;
        end else begin
            irqPending  <= selHit;
            irqVecValid <= irqAck;
            if (irqAck && selHit) begin
                irqVector <= {vbase_q, mrv_pkg::IRQ_OFS[selIdx]};
            end else if (irqAck) begin
                irqVector <= {vbase_q, mrv_pkg::OFS_SPURIOUS};
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    chk_hold_until_load: assert property (
        (state_q == mrv_pkg::ST_LOAD && !flashCfgDone) |=> cpuHold)
        else $error("cpu released before flash load done");
    chk_top_vector: assert property (
        (porEvt || illegalAddrEvt) |=> resetVec_q == 16'hfffe)
        else $error("top reset group vector wrong");
    chk_clkmon_gate: assert property (
        (!oscEn_q && !rstTop && !rstWdog && state_q == mrv_pkg::ST_RUN) |=> cpuHold == 1'b0)
        else $error("clock monitor reset without oscillator enable");
    chk_wdog_vector: assert property (
        (wdogTimeout && wdogRate_q != 3'h0 && !rstTop && !rstClk) |=>
        resetVec_q == 16'hfffa && state_q == mrv_pkg::ST_HOLD)
        else $error("watchdog reset vector wrong");
    chk_mode_capture: assert property (
        (state_q == mrv_pkg::ST_HOLD && !sysReq) |=> modeBit_q == $past(modeSync))
        else $error("mode not latched on reset release");
    chk_mode_oneway: assert property (
        (modeBit_q && state_q != mrv_pkg::ST_HOLD) |=> modeBit_q)
        else $error("mode switched back to special while running");
    chk_debug_follow: assert property (
        ##1 $changed(modeBit_q) |=> debugActive == ~$past(modeBit_q))
        else $error("debug active does not follow mode");
    chk_abort_now: assert property (
        (sysReq && flashCmdBusy) |=> flashAbort && status_q[mrv_pkg::EV_ABORT])
        else $error("flash command not aborted on reset");
    chk_spurious_vec: assert property (
        (irqAck && !selHit) |=> irqVecValid && irqVector[7:0] == 8'h80)
        else $error("spurious vector not returned");
    chk_vector_base: assert property (
        (irqAck && selHit) |=> irqVector[15:8] == $past(vbase_q) && irqVector[7:0] != 8'h80)
        else $error("vector not formed from base");
    chk_top_prio: assert property (
        (irqAck && irqReq[0]) |=> irqVector[7:0] == 8'hf8)
        else $error("unimplemented-instruction trap not highest");
    chk_part_id: assert property (
        (rdEn && paddr == 12'h068) |-> prdata == {24'h0, partId[15:8]})
        else $error("part id high byte wrong");
    chk_secure_set: assert property (
        (state_q == mrv_pkg::ST_LOAD && flashCfgDone && flashDoubleFault && !sysReq)
        |=> flashSecure)
        else $error("security not set after double fault");

    cov_load_done: cover property (state_q == mrv_pkg::ST_LOAD ##1 state_q == mrv_pkg::ST_RUN);
    cov_wdog_reset: cover property (rstWdog);
    cov_spurious:   cover property (irqAck && !selHit);
    cov_status_irq: cover property (irq ##1 rdEn);
endmodule

// file: tb/mrv_far_model.sv
// far-side model: flash configuration loader with fault injection
`timescale 1ns/1ns
module mrv_far_model (
    // clock and reset activity
    input  wire logic clk,
    input  wire logic srcActive,
    input  wire logic cpuHold,
    // pace and fault choice
    input  wire logic slow,
    input  wire logic faultIn,
    // loader results
    output logic      cfgDone,
    output logic      dblFault
);
    int loadCnt;
    // load restarts on any source so a stale done never leaks into a new sequence
    always_ff @(posedge clk) begin
        if (srcActive || !cpuHold) loadCnt <= 0;
        else loadCnt <= loadCnt + 1;
    end
    assign cfgDone  = loadCnt >= (slow ? 7 : 1);
    assign dblFault = cfgDone & faultIn;
endmodule

// file: tb/tb_top.sv
// self-checking bench for the reset, mode and vector block
`timescale 1ns/1ns
module tb_top;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, errv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0]  topSrc;
    logic        clkMonFail, wdogTimeout, modeSelectIn, flashCmdBusy, flashAbort;
    logic        flashSecure, cpuHold, monitorRun, debugActive, freezeOut, cpuIMask;
    logic        cpuXMask, irqAck, irqPending, irqVecValid, irq, cfgDone, dblFault;
    logic        slow, faultIn;
    logic [15:0] flashVersionId, cpuStartVector, irqVector, lastVec;
    logic [mrv_pkg::IRQ_N-1:0] irqReq;
    logic [7:0]  vb;
    logic [15:0] vq[$];
    int          seed = 32'h44cdd17a;
    int          bad_count = 0;
    int          checks_done = 0;
    int          expStat;

    mrv_top i_mrv_top (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .porEvt(topSrc[0]), .lowVoltEvt(topSrc[1]), .pinResetN(~topSrc[2]),
        .illegalAddrEvt(topSrc[3]), .clkMonFail(clkMonFail), .wdogTimeout(wdogTimeout),
        .modeSelectIn(modeSelectIn), .flashCfgDone(cfgDone), .flashDoubleFault(dblFault),
        .flashCmdBusy(flashCmdBusy), .flashVersionId(flashVersionId),
        .flashAbort(flashAbort), .flashSecure(flashSecure), .cpuHold(cpuHold),
        .cpuStartVector(cpuStartVector), .monitorRun(monitorRun), .debugActive(debugActive),
        .freezeOut(freezeOut), .irqReq(irqReq), .cpuIMask(cpuIMask), .cpuXMask(cpuXMask),
        .irqAck(irqAck), .irqPending(irqPending), .irqVector(irqVector),
        .irqVecValid(irqVecValid), .irq(irq));
    mrv_far_model i_mrv_far_model (.clk(clk), .cpuHold(cpuHold), .slow(slow),
        .srcActive(reset | (|topSrc) | clkMonFail | wdogTimeout), .faultIn(faultIn),
        .cfgDone(cfgDone), .dblFault(dblFault));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task complete_run;
        if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        {psel, penable, pwrite} <= {2'b10, wr};
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdv = prdata;
        errv = pslverr;
        {psel, penable} <= 2'h0;
    endtask

    task runWait;
        int n;
        n = 0;
        @(posedge clk);
        while (cpuHold !== 1'b0 && n < 64) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
    endtask

    task go(input logic msel);
        reset <= 1'b1;
        modeSelectIn <= msel;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        expStat = 0;
        runWait;
    endtask

    // k: 0..3 top group, 4 clock monitor, 5 watchdog; en: source locally enabled
    task fire(input int k, input logic en);
        logic fb, ab;
        fb = 1'($random(seed));
        ab = 1'b0;
        @(posedge clk);
        slow <= 1'($random(seed));
        faultIn <= (k == 3);
        flashCmdBusy <= fb;
        if (k < 4) topSrc <= 4'h1 << k;
        clkMonFail <= (k == 4);
        wdogTimeout <= (k == 5);
        // abort only stands while a source is active; a watchdog source falls early
        repeat (6) begin
            @(posedge clk);
            ab |= flashAbort;
        end
        chk(cpuHold, en);
        chk(ab, fb & en);
        {topSrc, clkMonFail, wdogTimeout, flashCmdBusy} <= 7'h0;
        runWait;
        chk(cpuHold, 1'b0);
        if (en) begin
            chk(cpuStartVector, k < 4 ? mrv_pkg::VEC_RESET : k == 4 ? mrv_pkg::VEC_CLKMON
                : mrv_pkg::VEC_WDOG);
            chk(flashSecure, k == 3);
            expStat |= (k == 4) << 3 | (k == 5) << 4 | fb << 1 | (k == 3) << 2;
        end
    endtask

    function automatic logic [15:0] expVec(logic [10:0] r, logic im, logic xm);
        for (int i = 0; i < mrv_pkg::IRQ_N; i++)
            if (r[i] && (mrv_pkg::IRQ_NOMASK[i] || (mrv_pkg::IRQ_XMASK[i] ? !xm : !im)))
                return {vb, mrv_pkg::IRQ_OFS[i]};
        return {vb, mrv_pkg::OFS_SPURIOUS};
    endfunction

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run;
    end

    initial begin
        {reset, psel, penable, pwrite, irqAck, cpuIMask, cpuXMask} = 7'h40;
        {topSrc, clkMonFail, wdogTimeout, flashCmdBusy, slow, faultIn} = 9'h0;
        {paddr, pwdata, irqReq, vb} = '0;
        modeSelectIn = 1'b1;
        flashVersionId = 16'($random(seed));
        go(1'b1);
        apb(1'b1, mrv_pkg::IDX_PART_HI, 32'hff);
        apb(1'b0, mrv_pkg::IDX_PART_HI, 32'h0);
        chk(rdv, 32'h10);
        apb(1'b0, mrv_pkg::IDX_PART_LO, 32'h0);
        chk(rdv, 32'h91);
        apb(1'b0, mrv_pkg::IDX_VERSION, 32'h0);
        chk(rdv, {16'h0, flashVersionId});
        apb(1'b0, 8'h3f, 32'h0);
        chk({rdv[30:0], errv}, 32'h1);
        apb(1'b1, mrv_pkg::IDX_MASK, 32'h1f);
        for (int k = 0; k < 6; k++) begin
            if (k == 4) apb(1'b1, mrv_pkg::IDX_OSC, 32'h0);
            if (k > 3) fire(k, 1'b0);
            if (k == 4) apb(1'b1, mrv_pkg::IDX_OSC, 32'h1);
            if (k == 5) apb(1'b1, mrv_pkg::IDX_WDOG, 32'h3);
            fire(k, 1'b1);
        end
        chk(irq, 1'b1);
        apb(1'b0, mrv_pkg::IDX_STATUS, 32'h0);
        chk(rdv, expStat);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        vb = 8'($random(seed));
        apb(1'b1, mrv_pkg::IDX_VBASE, {24'h0, vb});
        apb(1'b1, mrv_pkg::IDX_MASK, 32'h1e);
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            irqReq <= i == 0 ? 11'h0 : 11'($random(seed) & $random(seed) & $random(seed));
            {cpuIMask, cpuXMask} <= 2'($random(seed));
            irqAck <= 1'b1;
            @(posedge clk);
            irqAck <= 1'b0;
            vq.push_back(expVec(irqReq, cpuIMask, cpuXMask));
            @(posedge clk);
            chk(irqPending, vq[0][7:0] != mrv_pkg::OFS_SPURIOUS);
            chk(irqVecValid, 1'b1);
            lastVec = vq.pop_front();
            chk(irqVector, lastVec);
        end
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        apb(1'b1, mrv_pkg::IDX_MASK, 32'h1f);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        apb(1'b0, mrv_pkg::IDX_VECTOR, 32'h0);
        chk(rdv, {16'h0, lastVec});
        apb(1'b0, mrv_pkg::IDX_STATUS, 32'h0);
        chk(rdv, 32'h1);
        go(1'b0);
        chk({monitorRun, debugActive, cpuStartVector}, 18'h3ff00);
        apb(1'b0, mrv_pkg::IDX_MODE, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b1, mrv_pkg::IDX_MODE, 32'h2);
        repeat (2) @(posedge clk);
        chk(freezeOut, 1'b1);
        apb(1'b1, mrv_pkg::IDX_MODE, 32'h3);
        repeat (2) @(posedge clk);
        chk({debugActive, freezeOut}, 2'h0);
        apb(1'b0, mrv_pkg::IDX_MODE, 32'h0);
        chk(rdv, 32'h3);
        go(1'b1);
        chk({monitorRun, cpuStartVector}, {1'b0, mrv_pkg::VEC_RESET});
        complete_run;
    end
endmodule
